// ---- chm_monitor.sv ----
`timescale 1ns/1ps
module chm_monitor
  import chm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        cfg_osc,
  input  wire logic        jtag_ir_cfg,
  input  wire logic        cmd_wr,
  input  wire logic [31:0] cmd_data,
  input  wire logic        timer_wr,
  input  wire logic [31:0] timer_data,
  input  wire logic        sync_seen,
  input  wire logic        startup_done,
  input  wire logic        shutdown,
  input  wire logic        attempt_done,
  input  wire logic        attempt_crc_err,
  input  wire logic        attempt_wrap_err,
  input  wire logic        attempt_id_err,
  input  wire logic        attempt_internal_program,
  input  wire logic        attempt_fallback,
  input  wire logic        port_access,
  input  wire logic        bgchk_enable,
  input  wire logic        init_flag_en,
  input  wire logic        rb_valid,
  input  wire logic [31:0] rb_data,
  input  wire logic [1:0]  rb_kind,
  input  wire logic        rb_last,
  output logic [15:0]      boot_history_status,
  output logic             fallback_req,
  output logic             watchdog_active,
  output logic             background_check_error,
  output logic             bgchk_running,
  output logic             init_o,
  output logic             init_oe_n
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                 osc_s1;
    logic                 osc_s2;
    logic                 osc_prev;
    logic                 ir_s1;
    logic                 ir_s2;
    logic [CHM_PRE_W-1:0] pre;
    logic [CHM_WD_W-1:0]  wd_cnt;
    logic [31:0]          timer_val;
    logic                 wd_en;
    logic                 fb_lock;
    logic                 last_fb_ok;
    logic                 wto_pend;
    logic                 fb_req;
    logic [15:0]          bh;
    logic                 desynchronize_cmd_ok;
    logic [31:0]          crc_acc;
    logic [31:0]          golden;
    logic                 golden_ok;
    logic                 bg_err;
    logic                 init_drive;
  } chm_state_t;

  chm_state_t st_r;
  chm_state_t st_nxt;

  function automatic logic [31:0] chm_crc_step(input logic [31:0] crc, input logic [31:0] d);
    logic [31:0] c;
    c = crc;
    for (int i = 31; i >= 0; i--) begin
      c = (c[31] ^ d[i]) ? ((c << 1) ^ CHM_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : chm_crc_step

  logic tick;
  logic is_cmd_reload;
  logic is_cmd_desynchronize_cmd;
  logic is_cmd_regold;
  logic wd_load;
  logic expire;
  logic rb_run;
  logic att_ok;
  logic [7:0] new_entry;

  always_comb begin
    tick          = st_r.osc_s2 & ~st_r.osc_prev & (st_r.pre == {CHM_PRE_W{1'b1}});
    is_cmd_reload = cmd_wr & (cmd_data[4:0] == CHM_CMD_RELOAD);
    is_cmd_desynchronize_cmd = cmd_wr & (cmd_data[4:0] == CHM_CMD_DESYNCHRONIZE_CMD);
    is_cmd_regold = cmd_wr & ((cmd_data[4:0] == CHM_CMD_CRC_CLEAR) |
                              (cmd_data[4:0] == CHM_CMD_GLOB_ASRT));
    // Any port's write lands here, so no port check; the lock still wins
    wd_load       = (timer_wr & ~st_r.fb_lock &
                     (timer_data[CHM_TMR_CFG_MON] | timer_data[CHM_TMR_USR_MON])) |
                    (is_cmd_reload & st_r.wd_en);
    expire        = st_r.wd_en & tick & (st_r.wd_cnt == '0) &
                    (st_r.timer_val[CHM_TMR_USR_MON] |
                     (st_r.timer_val[CHM_TMR_CFG_MON] & ~startup_done));
    rb_run        = bgchk_enable & startup_done & st_r.desynchronize_cmd_ok &
                    ~port_access & ~st_r.ir_s2;
    att_ok        = ~attempt_crc_err & ~attempt_wrap_err & ~attempt_id_err;
    new_entry                  = '0;
    new_entry[CHM_BH_VALID]    = 1'b1;
    new_entry[CHM_BH_FALLBACK] = attempt_fallback;
    new_entry[CHM_BH_INTERNAL_PROGRAM]    = attempt_internal_program;
    new_entry[CHM_BH_WTO]      = st_r.wto_pend;
    new_entry[CHM_BH_ID]       = attempt_id_err;
    new_entry[CHM_BH_CRC]      = attempt_crc_err;
    new_entry[CHM_BH_WRAP]     = attempt_wrap_err;
    new_entry[CHM_BH_BGCHK]    = st_r.bg_err;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] acc;
    acc             = st_r.crc_acc;
    st_nxt          = st_r;
    st_nxt.osc_s1   = cfg_osc;
    st_nxt.osc_s2   = st_r.osc_s1;
    st_nxt.osc_prev = st_r.osc_s2;
    st_nxt.ir_s1    = jtag_ir_cfg;
    st_nxt.ir_s2    = st_r.ir_s1;
    st_nxt.fb_req   = 1'b0;
    if (st_r.osc_s2 & ~st_r.osc_prev) begin
      st_nxt.pre = st_r.pre + 1'b1;
    end
    // Watchdog
    if (timer_wr) begin
      st_nxt.timer_val = timer_data;
    end
    if (wd_load) begin
      st_nxt.wd_en  = 1'b1;
      st_nxt.wd_cnt = timer_wr ? timer_data[CHM_WD_W-1:0] : st_r.timer_val[CHM_WD_W-1:0];
    end else if (expire) begin
      st_nxt.wd_en    = 1'b0;
      st_nxt.fb_lock  = 1'b1;
      st_nxt.wto_pend = 1'b1;
      st_nxt.fb_req   = 1'b1;
    end else if (st_r.wd_en & tick & (st_r.wd_cnt != '0)) begin
      st_nxt.wd_cnt = st_r.wd_cnt - 1'b1;
    end
    if (shutdown) begin
      st_nxt.wd_en = 1'b0;
    end
    // Boot history
    if (attempt_done) begin
      st_nxt.bh       = {st_r.bh[CHM_BH_ENTRY_W-1:0], new_entry};
      // Expiry in this same cycle belongs to the fallback attempt that follows
      st_nxt.wto_pend = expire & ~wd_load;
      if (attempt_fallback) begin
        st_nxt.fb_lock = 1'b1;
        st_nxt.wd_en   = 1'b0;
      end else if (attempt_internal_program & att_ok & st_r.last_fb_ok) begin
        st_nxt.fb_lock = 1'b0;
      end
      st_nxt.last_fb_ok = attempt_fallback & att_ok;
    end
    // Background readback
    if (sync_seen) begin
      st_nxt.desynchronize_cmd_ok = 1'b0;
    end
    if (is_cmd_desynchronize_cmd) begin
      st_nxt.desynchronize_cmd_ok = 1'b1;
      st_nxt.golden_ok = 1'b0;
      st_nxt.bg_err    = 1'b0;
      st_nxt.crc_acc   = CHM_CRC_SEED;
    end else if (is_cmd_regold) begin
      st_nxt.golden_ok = 1'b0;
      st_nxt.crc_acc   = CHM_CRC_SEED;
    end else if (!rb_run) begin
      // A half-read round is useless after a pause, so restart it
      st_nxt.crc_acc = CHM_CRC_SEED;
      if (port_access) begin
        st_nxt.bg_err = 1'b0;
      end
    end else if (rb_valid) begin
      acc = st_r.crc_acc;
      if (rb_kind != CHM_RB_BRAM) begin
        acc = chm_crc_step(st_r.crc_acc,
                           (rb_kind == CHM_RB_PLAIN) ? rb_data : 32'h00000000);
      end
      if (rb_last) begin
        st_nxt.crc_acc = CHM_CRC_SEED;
        if (!st_r.golden_ok) begin
          st_nxt.golden    = acc;
          st_nxt.golden_ok = 1'b1;
        end else begin
          st_nxt.bg_err = (acc != st_r.golden);
        end
      end else begin
        st_nxt.crc_acc = acc;
      end
    end
    st_nxt.init_drive = st_nxt.bg_err & init_flag_en;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r           <= '0;
      st_r.bh        <= CHM_BH_RESET;
      st_r.crc_acc   <= CHM_CRC_SEED;
      st_r.desynchronize_cmd_ok <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign boot_history_status    = st_r.bh;
  assign fallback_req           = st_r.fb_req;
  assign watchdog_active        = st_r.wd_en;
  assign background_check_error = st_r.bg_err;
  assign bgchk_running          = rb_run;
  assign init_o                 = 1'b0;
  assign init_oe_n              = ~st_r.init_drive;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  hist_shift_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    attempt_done |=> (st_r.bh[15:8] == $past(st_r.bh[7:0])) && st_r.bh[CHM_BH_VALID])
    else $error("history did not shift");
  hist_entry_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    attempt_done && attempt_internal_program && attempt_fallback |=> st_r.bh[2:0] == 3'h7)
    else $error("history entry flags wrong");
  wto_record_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    attempt_done && (fallback_req || st_r.wto_pend) |=> st_r.bh[CHM_BH_WTO])
    else $error("timeout not recorded");
  expire_fb_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    fallback_req |-> !watchdog_active && st_r.fb_lock && $past(st_r.wd_cnt) == '0)
    else $error("fallback without expiry");
  wd_lock_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_r.fb_lock && !watchdog_active && !attempt_done |=> !watchdog_active)
    else $error("watchdog enabled under lock");
  reload_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cmd_wr && cmd_data[4:0] == CHM_CMD_RELOAD && watchdog_active && !timer_wr && !shutdown
    |=> st_r.wd_cnt == st_r.timer_val[CHM_WD_W-1:0] && watchdog_active)
    else $error("reload did not restart count");
  slow_tick_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    watchdog_active && !$past(wd_load) && st_r.wd_cnt != '0 && st_r.wd_cnt != $past(st_r.wd_cnt)
    |-> $past(st_r.pre) == {CHM_PRE_W{1'b1}})
    else $error("watchdog ticked off prescale");
  desynchronize_cmd_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    cmd_wr && cmd_data[4:0] == CHM_CMD_DESYNCHRONIZE_CMD |=> !background_check_error && !st_r.golden_ok)
    else $error("desynchronize_cmd left check state");
  access_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    port_access |=> !background_check_error && init_oe_n)
    else $error("access left error set");
  init_pin_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    background_check_error && init_flag_en && $stable(init_flag_en) && $stable(background_check_error)
    |-> !init_oe_n)
    else $error("init pin not pulled low");
  ir_halt_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(jtag_ir_cfg, 2) |-> !bgchk_running)
    else $error("readback ran under config instruction");
endmodule : chm_monitor

// ---- chm_pkg.sv ----
package chm_pkg;
  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  localparam int          CHM_PRESCALE       = 256;
  localparam int          CHM_PRE_W          = $clog2(CHM_PRESCALE);
  localparam int          CHM_WD_W           = 24;
  localparam int          CHM_TMR_CFG_MON    = 30;
  localparam int          CHM_TMR_USR_MON    = 31;
  // ---------------------------------------------------------------
  // Command register codes
  // ---------------------------------------------------------------
  localparam logic [4:0]  CHM_CMD_RELOAD     = 5'h11;
  localparam logic [4:0]  CHM_CMD_DESYNCHRONIZE_CMD     = 5'h0d;
  localparam logic [4:0]  CHM_CMD_CRC_CLEAR  = 5'h07;
  localparam logic [4:0]  CHM_CMD_GLOB_ASRT  = 5'h08;
  // ---------------------------------------------------------------
  // Boot history entry bits, newest entry in [7:0]
  // ---------------------------------------------------------------
  localparam int          CHM_BH_ENTRY_W     = 8;
  localparam int          CHM_BH_VALID       = 0;
  localparam int          CHM_BH_FALLBACK    = 1;
  localparam int          CHM_BH_INTERNAL_PROGRAM       = 2;
  localparam int          CHM_BH_WTO         = 3;
  localparam int          CHM_BH_ID          = 4;
  localparam int          CHM_BH_CRC         = 5;
  localparam int          CHM_BH_WRAP        = 6;
  localparam int          CHM_BH_BGCHK       = 7;
  localparam logic [15:0] CHM_BH_RESET       = 16'h0000;
  // ---------------------------------------------------------------
  // Background readback word kinds and CRC
  // ---------------------------------------------------------------
  localparam logic [1:0]  CHM_RB_PLAIN       = 2'h0;
  localparam logic [1:0]  CHM_RB_LUT_MEM     = 2'h1;
  localparam logic [1:0]  CHM_RB_DRP_MEM     = 2'h2;
  localparam logic [1:0]  CHM_RB_BRAM        = 2'h3;
  localparam logic [31:0] CHM_CRC_POLY       = 32'h1edc6f41;
  localparam logic [31:0] CHM_CRC_SEED       = 32'hffffffff;
endpackage : chm_pkg

// ---- chm_cfg_source.sv ----
`timescale 1ns/1ps
module chm_cfg_source
  import chm_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             cfg_osc,
  output logic             cmd_wr,
  output logic [31:0]      cmd_data,
  output logic             timer_wr,
  output logic [31:0]      timer_data,
  output logic             sync_seen
);
  // ---------------------------------------------------------------
  // Free-running oscillator, phase unrelated to clk_sys
  // ---------------------------------------------------------------
  initial begin
    cfg_osc    = 1'b0;
    cmd_wr     = 1'b0;
    cmd_data   = 32'h0;
    timer_wr   = 1'b0;
    timer_data = 32'h0;
    sync_seen  = 1'b0;
    forever #23 cfg_osc = ~cfg_osc;
  end
  // ---------------------------------------------------------------
  // Port words, one clock each
  // ---------------------------------------------------------------
  task automatic pulse_sync;
    @(posedge clk_sys);
    sync_seen <= 1'b1;
    @(posedge clk_sys);
    sync_seen <= 1'b0;
  endtask : pulse_sync
  task automatic put_cmd(input logic [4:0] code);
    @(posedge clk_sys);
    cmd_wr   <= 1'b1;
    cmd_data <= {27'h0, code};
    @(posedge clk_sys);
    cmd_wr   <= 1'b0;
    // Released bus shows garbage, not the old word
    cmd_data <= ~{27'h0, code};
  endtask : put_cmd
  task automatic reload_seq;
    pulse_sync();
    put_cmd(5'h00);
    put_cmd(CHM_CMD_RELOAD);
    put_cmd(CHM_CMD_DESYNCHRONIZE_CMD);
  endtask : reload_seq
  task automatic timer_seq(input logic [31:0] v);
    pulse_sync();
    @(posedge clk_sys);
    timer_wr   <= 1'b1;
    timer_data <= v;
    @(posedge clk_sys);
    timer_wr   <= 1'b0;
    timer_data <= ~v;
    put_cmd(CHM_CMD_DESYNCHRONIZE_CMD);
  endtask : timer_seq
endmodule : chm_cfg_source

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import chm_pkg::*;
  logic        clk_sys, nrst, cfg_osc, jtag_ir_cfg, cmd_wr, timer_wr, sync_seen, startup_done, shutdown;
  logic        attempt_done, attempt_crc_err, attempt_wrap_err, attempt_id_err, attempt_internal_program, attempt_fallback;
  logic        port_access, bgchk_enable, init_flag_en, rb_valid, rb_last, fallback_req, watchdog_active;
  logic        background_check_error, bgchk_running, init_o, init_oe_n, gold_ok, err_m, wto_pend;
  logic [31:0] cmd_data, timer_data, rb_data, gold, rd[4];
  logic [15:0] boot_history_status;
  logic [7:0]  newest, older;
  logic [1:0]  rb_kind, rk[4];
  int          fail_count, checks, fb_seen, n;

  chm_cfg_source chm_cfg_source_i (.clk_sys, .cfg_osc, .cmd_wr, .cmd_data, .timer_wr, .timer_data, .sync_seen);
  chm_monitor chm_monitor_i (.clk_sys, .nrst, .cfg_osc, .jtag_ir_cfg, .cmd_wr, .cmd_data, .timer_wr,
    .timer_data, .sync_seen, .startup_done, .shutdown, .attempt_done, .attempt_crc_err, .attempt_wrap_err,
    .attempt_id_err, .attempt_internal_program, .attempt_fallback, .port_access, .bgchk_enable, .init_flag_en, .rb_valid,
    .rb_data, .rb_kind, .rb_last, .boot_history_status, .fallback_req, .watchdog_active,
    .background_check_error, .bgchk_running, .init_o, .init_oe_n);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (fallback_req === 1'b1) begin
    fb_seen <= fb_seen + 1;
    wto_pend <= 1'b1;
  end
  // ---------------------------------------------------------------
  // Checking and reference model
  // ---------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  // Flags {wrap, crc, id, internal_program, fallback}
  task automatic attempt(input logic [4:0] f);
    @(posedge clk_sys);
    attempt_done <= 1'b1;
    {attempt_wrap_err, attempt_crc_err, attempt_id_err, attempt_internal_program, attempt_fallback} <= f;
    @(posedge clk_sys);
    attempt_done <= 1'b0;
    older = newest;
    newest = {1'b0, f[4:2], wto_pend, f[1:0], 1'b1};
    wto_pend = 1'b0;
    #1 cmp("history", {older, newest}, boot_history_status);
  endtask : attempt
  // Signature of a round: masked kinds fold zero, block RAM skipped
  task automatic round(input logic ie);
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      rb_valid <= 1'b1;
      rb_data  <= rd[i];
      rb_kind  <= rk[i];
      rb_last  <= (i == 3);
      if (rk[i] != CHM_RB_BRAM) s = {s[30:0], s[31]} ^ ((rk[i] == CHM_RB_PLAIN) ? rd[i] : 32'h0);
    end
    @(posedge clk_sys);
    rb_valid <= 1'b0;
    rb_last  <= 1'b0;
    err_m = gold_ok && (s != gold);
    if (!gold_ok) gold = s;
    gold_ok = 1'b1;
    #1 cmp("bgchk_error", {15'h0, err_m}, {15'h0, background_check_error});
    cmp("init_oe_n", {15'h0, !(err_m && ie)}, {15'h0, init_oe_n});
    cmp("init_o", 16'h0, {15'h0, init_o});
  endtask : round
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : idle
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h1c670cc8));
    {nrst, jtag_ir_cfg, startup_done, shutdown, attempt_done, port_access, rb_valid, rb_last} = '0;
    {attempt_crc_err, attempt_wrap_err, attempt_id_err, attempt_internal_program, attempt_fallback} = '0;
    {bgchk_enable, init_flag_en, rb_data, rb_kind} = '0;
    {newest, older, wto_pend, gold_ok, gold, fb_seen, fail_count, checks} = '0;
    rk = '{CHM_RB_PLAIN, CHM_RB_LUT_MEM, CHM_RB_DRP_MEM, CHM_RB_BRAM};
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    idle(1);
    cmp("history", 16'h0000, boot_history_status);
    attempt(5'b00000);
    attempt(5'b00010);
    chm_cfg_source_i.timer_seq({2'b10, 6'h0, 24'h3});
    idle(1);
    cmp("wd_active", 16'h1, {15'h0, watchdog_active});
    for (n = 0; n < 4; n++) begin
      repeat (900 + $urandom_range(500)) @(posedge clk_sys);
      if (n[0]) chm_cfg_source_i.reload_seq();
      else chm_cfg_source_i.timer_seq({2'b10, 6'h0, 24'h3});
    end
    shutdown <= 1'b1;
    idle(1);
    shutdown <= 1'b0;
    cmp("wd_off", 16'h0, {15'h0, watchdog_active});
    startup_done <= 1'b1;
    chm_cfg_source_i.timer_seq({2'b01, 6'h0, 24'h2});
    idle(5000);
    cmp("no_fallback", 16'h0, fb_seen[15:0]);
    shutdown <= 1'b1;
    startup_done <= 1'b0;
    idle(1);
    shutdown <= 1'b0;
    chm_cfg_source_i.timer_seq({2'b01, 6'h0, 24'h2});
    for (n = 0; n < 6000 && fb_seen == 0; n++) @(posedge clk_sys);
    idle(1);
    cmp("fallback", 16'h1, fb_seen[15:0]);
    cmp("wd_slow", 16'h1, {15'h0, n > 2 * CHM_PRESCALE * 46 / 10 - 10});
    cmp("wd_off", 16'h0, {15'h0, watchdog_active});
    attempt(5'b00011);
    chm_cfg_source_i.timer_seq({2'b10, 6'h0, 24'h40});
    idle(1);
    cmp("wd_locked", 16'h0, {15'h0, watchdog_active});
    attempt(5'b00010);
    chm_cfg_source_i.timer_seq({2'b10, 6'h0, 24'h40});
    idle(1);
    cmp("wd_rearmed", 16'h1, {15'h0, watchdog_active});
    shutdown <= 1'b1;
    idle(1);
    shutdown <= 1'b0;
    attempt(5'b01010);
    attempt(5'b00011);
    startup_done <= 1'b1;
    bgchk_enable <= 1'b1;
    init_flag_en <= 1'b1;
    for (n = 0; n < 4; n++) rd[n] = $urandom;
    idle(2);
    cmp("running", 16'h1, {15'h0, bgchk_running});
    round(1'b1);
    for (n = 1; n < 4; n++) rd[n] = ~rd[n];
    round(1'b1);
    rd[0][5] = ~rd[0][5];
    round(1'b1);
    idle(20);
    cmp("err_held", 16'h1, {15'h0, background_check_error});
    port_access <= 1'b1;
    idle(2);
    cmp("err_clr", 16'h0, {15'h0, background_check_error});
    cmp("paused", 16'h0, {15'h0, bgchk_running});
    port_access <= 1'b0;
    rd[0][5] = ~rd[0][5];
    round(1'b1);
    init_flag_en <= 1'b0;
    rd[0][9] = ~rd[0][9];
    round(1'b0);
    chm_cfg_source_i.put_cmd(CHM_CMD_DESYNCHRONIZE_CMD);
    #1 cmp("desynchronize_cmd_clr", 16'h0, {15'h0, background_check_error});
    gold_ok = 1'b0;
    jtag_ir_cfg <= 1'b1;
    idle(4);
    cmp("jtag_halt", 16'h0, {15'h0, bgchk_running});
    jtag_ir_cfg <= 1'b0;
    chm_cfg_source_i.pulse_sync();
    idle(4);
    cmp("sync_halt", 16'h0, {15'h0, bgchk_running});
    chm_cfg_source_i.put_cmd(CHM_CMD_DESYNCHRONIZE_CMD);
    round(1'b0);
    chm_cfg_source_i.put_cmd(CHM_CMD_CRC_CLEAR);
    gold_ok = 1'b0;
    rd[0] = $urandom;
    round(1'b0);
    chm_cfg_source_i.put_cmd(CHM_CMD_GLOB_ASRT);
    gold_ok = 1'b0;
    rd[2] = ~rd[0];
    round(1'b0);
    round(1'b0);
    cmp("fallback_total", 16'h1, fb_seen[15:0]);
    complete_run();
  end
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule : tb
